// ---- dv/asr_axis_ctrl_sva.sv ----
// Purpose: Port checks for the axis control block
// Assumes: One clock, synchronous active-high reset
// Notes:   Active axis mirrored from register writes
`timescale 1ns/1ns
module asr_axis_ctrl_sva #(
  parameter int AXES  = 4,
  parameter int POS_W = 32,
  parameter int VEL_W = 16
) (
  // Clock, reset, register port
  input wire logic                            clock_i,
  input wire logic                            rst_i,
  input wire asr_pkg::asr_req_type            req_i,
  input wire logic [31:0]                     rdata_o,
  // Core side
  input wire logic [AXES*VEL_W-1:0]           vel_i,
  input wire logic [AXES-1:0]                 amp_en_o,
  input wire logic [AXES-1:0]                 brake_o,
  input wire logic [1:0]                      enc_differential_input_o,
  input wire logic [VEL_W-1:0]                monitor_o,
  input wire asr_pkg::asr_move_type [AXES-1:0] move_o
);
  logic [1:0] sel_r;
  logic       wa;
  logic [VEL_W-1:0] vsel;
  // Velocity of the mirrored active axis
  assign vsel = vel_i[sel_r*VEL_W+:VEL_W];
  // ****************
  // Helper logic
  // ****************
  assign wa = req_i.wr;
  // Mirror of the active axis, bad values ignored
  always_ff @(posedge clock_i) begin
    if (rst_i) sel_r <= 2'h0;
    else if (wa && req_i.addr == asr_pkg::OFS_AXIS_SEL &&
             req_i.wdata inside {[1:4]}) sel_r <= req_i.wdata[1:0] - 2'h1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ****************
  // Assertions
  // ****************
  a_rdata_quiet: assert property (!$past(req_i.rd) |-> rdata_o == 0)
    else $error("read data not zero outside read");
  a_sel_readback: assert property (req_i.rd && req_i.addr ==
    asr_pkg::OFS_AXIS_SEL |=> rdata_o == {30'h0, sel_r} + 32'h1)
    else $error("active axis readback wrong");
  a_monitor_follow: assert property ($stable(sel_r) && !$past(rst_i) |->
    monitor_o == $past(vsel))
    else $error("monitor not active axis velocity");
  a_run_enabled: assert property (move_o[0].run |->
    amp_en_o[0] || $past(amp_en_o[0]))
    else $error("search runs on disabled axis");
  a_amp_cause: assert property ($changed(amp_en_o) |-> $past(wa &&
    req_i.addr == asr_pkg::OFS_AXIS_CTRL))
    else $error("amplifier changed without control write");
  a_brake_cause: assert property ($changed(brake_o) && !$past(rst_i) &&
    !$past(rst_i, 2) |-> $past(wa && (req_i.addr == asr_pkg::OFS_BRAKE ||
    req_i.addr == asr_pkg::OFS_AXIS_CTRL)))
    else $error("brake changed without command");
  a_enc_cause: assert property ($changed(enc_differential_input_o) |-> $past(wa &&
    req_i.addr == asr_pkg::OFS_ENC_MODE))
    else $error("encoder mode changed without write");
  a_shift_cause: assert property (move_o[0].shift_stb |-> $past(wa &&
    req_i.addr == asr_pkg::OFS_POS_SET))
    else $error("target shift without position set");
  c_search: cover property (move_o[0].run);
  c_shift: cover property (move_o[0].shift_stb);
  c_sel_read: cover property (req_i.rd && req_i.addr == 8'h00);
endmodule // asr_axis_ctrl_sva
bind asr_axis_ctrl asr_axis_ctrl_sva #(
  .AXES(AXES), .POS_W(POS_W), .VEL_W(VEL_W)
) asr_axis_ctrl_sva_i (
  .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .vel_i(vel_i), .amp_en_o(amp_en_o), .brake_o(brake_o),
  .enc_differential_input_o(enc_differential_input_o), .monitor_o(monitor_o), .move_o(move_o)
);

// ---- dv/asr_stage_model.sv ----
// Purpose: Stage model toggling the reference edge during a search
// Assumes: moving follows run; DLY sets how slow the edge comes
// Notes:   Edge holds its level outside searches
`timescale 1ns/1ns
module asr_stage_model #(
  parameter int DLY = 20
) (
  // Clock and motion drive
  input  wire logic                        clock_i,
  input  wire asr_pkg::asr_move_type [3:0] move_i,
  // Stage pins
  output logic [3:0]                       edge_o,
  output logic [3:0]                       moving_o
);
  int cnt [4];
  initial edge_o = 4'h0;
  // Edge toggles after DLY cycles of running
  always @(posedge clock_i) begin
    for (int a = 0; a < 4; a++) begin
      cnt[a] <= move_i[a].run ? cnt[a] + 1 : 0;
      if (cnt[a] == DLY) edge_o[a] <= ~edge_o[a];
    end
  end
  assign moving_o = {move_i[3].run, move_i[2].run, move_i[1].run,
                     move_i[0].run};
endmodule // asr_stage_model

// ---- dv/testbench.sv ----
// Purpose: Directed tests of the axis control block
// Assumes: Stage model answers searches
// Notes:   Each access takes two cycles
`timescale 1ns/1ns
module testbench;
  logic clock_i, rst_i;
  asr_pkg::asr_req_type req;
  logic [31:0] rdata, v, shv;
  logic [3:0] lvl, edg, up, dn, mov, amp, brk;
  logic [63:0] vel;
  logic [1:0] enc;
  logic [15:0] mon;
  asr_pkg::asr_move_type [3:0] mv;
  int n_mismatch, compares;
  asr_axis_ctrl asr_axis_ctrl_i (.clock_i(clock_i), .rst_i(rst_i),
    .req_i(req), .rdata_o(rdata), .ref_level_i(lvl), .ref_edge_i(edg),
    .enc_up_i(up), .enc_dn_i(dn), .moving_i(mov), .vel_i(vel),
    .amp_en_o(amp), .brake_o(brk), .enc_differential_input_o(enc), .monitor_o(mon),
    .move_o(mv));
  asr_stage_model asr_stage_model_i (.clock_i(clock_i), .move_i(mv),
    .edge_o(edg), .moving_o(mov));
  // Catch target shifts of axis one
  always @(posedge clock_i) if (mv[0].shift_stb) shv <= mv[0].target_shift;
  task automatic chk(input string s, input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_i);
    req <= '0;
    @(posedge clock_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clock_i);
    req <= '0;
    #1 d = rdata;
    @(posedge clock_i);
    #1;
  endtask
  task automatic idle();
    for (int i = 0; i < 200 && mov !== 4'h0; i++) @(posedge clock_i);
    #1;
  endtask
  // Search on axis one with option o and level l
  task automatic srch(input logic [1:0] o, input logic l);
    lvl <= {4{l}};
    repeat (4) @(posedge clock_i);
    wr(asr_pkg::OFS_SEARCH, {30'h0, o});
    chk("run", mv[0].run, 1'b1);
    chk("dir", mv[0].dir_neg, o == 1 || (o == 2 && !l) || (o == 3 && l));
    idle();
    rd(asr_pkg::OFS_AXIS_STAT, v);
    chk("found", v[asr_pkg::STAT_REF_BIT], 1'b1);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  // Watchdog
  initial begin
    #100000 n_mismatch++;
    end_of_test();
  end
  initial begin
    rst_i = 1;
    req = '0;
    {lvl, up, dn} = '0;
    vel = 64'h4444_3333_2222_1111;
    repeat (5) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    #1 chk("amp", amp, 4'h0);
    chk("brake", brk, 4'h0);
    rd(asr_pkg::OFS_POS_READ, v);
    chk("pos", v, 0);
    for (int a = 1; a <= 4; a++) begin
      wr(asr_pkg::OFS_AXIS_SEL, a);
      rd(asr_pkg::OFS_AXIS_SEL, v);
      chk("sel", v, a);
      chk("mon", mon, vel[(a-1)*16+:16]);
    end
    wr(asr_pkg::OFS_AXIS_SEL, 5);
    wr(asr_pkg::OFS_AXIS_SEL, 0);
    rd(asr_pkg::OFS_AXIS_SEL, v);
    chk("sel", v, 4);
    rd(8'h40, v);
    chk("unmapped", v, 0);
    $display("test select done");
    wr(asr_pkg::OFS_AXIS_SEL, 2);
    wr(asr_pkg::OFS_AXIS_CTRL, 1);
    chk("amp", amp, 4'h2);
    wr(asr_pkg::OFS_AXIS_CTRL, 0);
    chk("amp", amp, 4'h0);
    wr(asr_pkg::OFS_SEARCH, 0);
    chk("run", mv[1].run, 1'b0);
    wr(asr_pkg::OFS_AXIS_CTRL, 1);
    chk("run", mv[1].run, 1'b1);
    idle();
    $display("test enable done");
    wr(asr_pkg::OFS_AXIS_SEL, 1);
    wr(asr_pkg::OFS_AXIS_CTRL, 1);
    rd(asr_pkg::OFS_AXIS_STAT, v);
    chk("found", v[asr_pkg::STAT_REF_BIT], 1'b0);
    // All four options are tried at both levels, then one more positive search
    for (int k = 0; k < 8; k++) srch(k[2:1], k[0]);
    srch(2'h0, 1'b0);
    $display("test search done");
    wr(asr_pkg::OFS_POS_SET, 1024);
    up <= 4'h1;
    repeat (3) @(posedge clock_i);
    up <= 4'h0;
    rd(asr_pkg::OFS_POS_READ, v);
    chk("pos", v, 1027);
    wr(asr_pkg::OFS_POS_SET, 32'h0000_0008);
    rd(asr_pkg::OFS_POS_READ, v);
    chk("pos", v, 0);
    wr(asr_pkg::OFS_SEARCH, 0);
    wr(asr_pkg::OFS_POS_SET, 500);
    chk("shift", shv, 500);
    idle();
    wr(asr_pkg::OFS_AXIS_SEL, 2);
    rd(asr_pkg::OFS_POS_READ, v);
    chk("pos", v, 0);
    $display("test position done");
    wr(asr_pkg::OFS_BRAKE, 5);
    chk("brake", brk, 4'h2);
    rd(asr_pkg::OFS_AXIS_STAT, v);
    chk("brake", v[asr_pkg::STAT_BRAKE_BIT], 1'b1);
    wr(asr_pkg::OFS_BRAKE, 0);
    chk("brake", brk, 4'h0);
    wr(asr_pkg::OFS_AXIS_CTRL, 3);
    rd(asr_pkg::OFS_AXIS_STAT, v);
    chk("pwrdef", v[asr_pkg::STAT_PWRBRAKE_BIT], 1'b1);
    wr(asr_pkg::OFS_AXIS_SEL, 3);
    wr(asr_pkg::OFS_ENC_MODE, 1);
    chk("enc", enc, 2'h2);
    rd(asr_pkg::OFS_ENC_MODE, v);
    chk("enc", v[1:0], 2'h2);
    rst_i <= 1;
    repeat (3) @(posedge clock_i);
    #1 chk("brake", brk, 4'hF);
    rst_i <= 0;
    $display("test brake done");
    repeat (3) @(posedge clock_i);
    end_of_test();
  end
endmodule // testbench

// ---- hw/asr_axis_ctrl.sv ----
// Purpose: Per-axis enable, brake, position and reference search; encoder mode per axis pair
// Assumes: Pins are asynchronous and synchronised here; one clock domain
// Notes:   Commands arrive as register writes and act on the active axis
//
// What this block does
// - Positive option searches in positive direction
// - Negative option searches in negative direction
// - Level option: high searches positive, low negative
// - Inverted level option: high negative, low positive
// - Reference status reads found or not found
// - Active axis one to four steers commands
// - Monitor output follows active axis velocity
// - Active axis readable back
// - Disabled axis has amplifier switched off
// - Settings held while disabled, applied on enable
// - Brake command drives brake; status readable
// - Brake argument zero releases, nonzero engages
// - Power-up brake default stored and readable; reset clears it, so brake releases after reset
// - Encoder mode set per axis pair
// - Counter clears at reset, loadable by command
// - Origin option loads zero counts
// - Reload while moving shifts target equally
// - Position read gives active axis count
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns

module asr_axis_ctrl #(
  parameter int AXES  = asr_pkg::AXES,
  parameter int POS_W = asr_pkg::POS_W,
  parameter int VEL_W = 16
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  // Register port
  input  wire asr_pkg::asr_req_type   req_i,
  output logic [31:0]                 rdata_o,
  // Pins from stages
  input  wire logic [AXES-1:0]        ref_level_i,
  input  wire logic [AXES-1:0]        ref_edge_i,
  // Encoder count pulses from decoders
  input  wire logic [AXES-1:0]        enc_up_i,
  input  wire logic [AXES-1:0]        enc_dn_i,
  // Motion core status and velocities
  input  wire logic [AXES-1:0]        moving_i,
  input  wire logic [AXES*VEL_W-1:0]  vel_i,
  // Outputs to power stage and motion core
  output logic [AXES-1:0]             amp_en_o,
  output logic [AXES-1:0]             brake_o,
  output logic [1:0]                  enc_differential_input_o,
  output logic [VEL_W-1:0]            monitor_o,
  output asr_pkg::asr_move_type [AXES-1:0] move_o
);

  // ************************************************************
  // Decode
  // ************************************************************
  logic [asr_pkg::AXIS_W-1:0] axis_r;
  logic wr_sel, wr_ctrl, wr_enc, wr_pos, wr_srch, wr_brk;
  // Write strobes per register
  assign wr_sel  = req_i.wr && req_i.addr == asr_pkg::OFS_AXIS_SEL;
  assign wr_ctrl = req_i.wr && req_i.addr == asr_pkg::OFS_AXIS_CTRL;
  assign wr_enc  = req_i.wr && req_i.addr == asr_pkg::OFS_ENC_MODE;
  assign wr_pos  = req_i.wr && req_i.addr == asr_pkg::OFS_POS_SET;
  assign wr_srch = req_i.wr && req_i.addr == asr_pkg::OFS_SEARCH;
  assign wr_brk  = req_i.wr && req_i.addr == asr_pkg::OFS_BRAKE;

  // Axis select: value 1..4 held as 0..3, others ignored
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      axis_r <= asr_pkg::AXIS_RESET;
    end else if (wr_sel && req_i.wdata >= 32'h0000_0001
                 && req_i.wdata <= 32'h0000_0004) begin
      axis_r <= asr_pkg::AXIS_W'(req_i.wdata - 32'h0000_0001);
    end
  end

  // Encoder detection per pair
  logic [1:0] enc_r;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      enc_r <= 2'h0;
    end else if (wr_enc) begin
      // Active axis picks its pair
      enc_r[axis_r[1]] <= req_i.wdata[0];
    end
  end
  assign enc_differential_input_o = enc_r;

  // Monitor routing registered from selected axis
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      monitor_o <= '0;
    end else begin
      monitor_o <= vel_i[axis_r*VEL_W +: VEL_W];
    end
  end

  // ************************************************************
  // Per-axis logic
  // ************************************************************
  logic [AXES-1:0]       en_r, brk_r, pwr_r, found_r, srch_r, dir_r;
  logic [AXES-1:0]       lvl_m_r, lvl_r, edg_m_r, edg_r, edg_d_r;
  logic [POS_W-1:0]      pos_r [AXES];
  asr_pkg::asr_move_type mv_r  [AXES];

  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      logic act;
      logic [POS_W-1:0] newpos;
      assign act    = axis_r == asr_pkg::AXIS_W'(g);
      // Origin flag loads zero counts, else the written value
      assign newpos = req_i.wdata[asr_pkg::CTRL_ORIGIN_BIT]
                      ? asr_pkg::POS_ORIGIN : POS_W'(req_i.wdata);

      // Two-flop synchronisers for stage pins
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          lvl_m_r[g] <= 1'b0;
          lvl_r[g]   <= 1'b0;
          edg_m_r[g] <= 1'b0;
          edg_r[g]   <= 1'b0;
          edg_d_r[g] <= 1'b0;
        end else begin
          lvl_m_r[g] <= ref_level_i[g];
          lvl_r[g]   <= lvl_m_r[g];
          edg_m_r[g] <= ref_edge_i[g];
          edg_r[g]   <= edg_m_r[g];
          edg_d_r[g] <= edg_r[g];
        end
      end

      // Enable and power-up brake default
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          en_r[g]  <= 1'b0;
          pwr_r[g] <= 1'b0;
        end else if (wr_ctrl && act) begin
          en_r[g]  <= req_i.wdata[asr_pkg::CTRL_ENABLE_BIT];
          pwr_r[g] <= req_i.wdata[asr_pkg::CTRL_PWRBRAKE_BIT];
        end
      end
      // Settings kept while off; amplifier gated here, search run gated by enable at move_o
      assign amp_en_o[g] = en_r[g];

      // Brake: reset clamps, default from stored flag once running
      logic boot_r;
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          brk_r[g]  <= 1'b1;
          boot_r    <= 1'b1;
        end else if (wr_brk && act) begin
          brk_r[g]  <= |req_i.wdata;
          boot_r    <= 1'b0;
        end else if (boot_r) begin
          brk_r[g]  <= pwr_r[g];
          boot_r    <= 1'b0;
        end
      end
      assign brake_o[g] = brk_r[g];

      // Reference search start, direction and completion
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          srch_r[g]  <= 1'b0;
          dir_r[g]   <= 1'b0;
          found_r[g] <= 1'b0;
        end else if (wr_srch && act) begin
          srch_r[g]  <= 1'b1;
          found_r[g] <= 1'b0;
          case (asr_pkg::asr_search_type'(req_i.wdata[1:0]))
            asr_pkg::SRCH_POS:       dir_r[g] <= 1'b0;
            asr_pkg::SRCH_NEG:       dir_r[g] <= 1'b1;
            asr_pkg::SRCH_LEVEL:     dir_r[g] <= ~lvl_r[g];
            asr_pkg::SRCH_LEVEL_INV: dir_r[g] <= lvl_r[g];
            default:                 dir_r[g] <= 1'b0;
          endcase
        end else if (srch_r[g] && (edg_r[g] != edg_d_r[g])) begin
          srch_r[g]  <= 1'b0;
          found_r[g] <= 1'b1;
        end
      end

      // Position counter with load and target shift
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          pos_r[g] <= asr_pkg::POS_ORIGIN;
          mv_r[g].shift_stb    <= 1'b0;
          mv_r[g].target_shift <= '0;
        end else if (wr_pos && act) begin
          // Origin option gives zero counts
          pos_r[g] <= newpos;
          mv_r[g].shift_stb    <= moving_i[g];
          mv_r[g].target_shift <= newpos - pos_r[g];
        end else begin
          mv_r[g].shift_stb <= 1'b0;
          if (enc_up_i[g] && !enc_dn_i[g]) begin
            pos_r[g] <= pos_r[g] + 1'b1;
          end else if (enc_dn_i[g] && !enc_up_i[g]) begin
            pos_r[g] <= pos_r[g] - 1'b1;
          end
        end
      end

      assign move_o[g].run          = srch_r[g] && en_r[g];
      assign move_o[g].dir_neg      = dir_r[g];
      assign move_o[g].target_shift = mv_r[g].target_shift;
      assign move_o[g].shift_stb    = mv_r[g].shift_stb;
    end
  endgenerate

  // ************************************************************
  // Read back, data one cycle after strobe
  // ************************************************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= asr_pkg::ZERO_WORD;
    end else if (req_i.rd) begin
      rdata_o <= asr_pkg::ZERO_WORD;
      case (req_i.addr)
        asr_pkg::OFS_AXIS_SEL:
          rdata_o <= 32'(axis_r) + 32'h0000_0001;
        asr_pkg::OFS_AXIS_STAT: begin
          rdata_o[asr_pkg::STAT_ENABLE_BIT]   <= en_r[axis_r];
          rdata_o[asr_pkg::STAT_BRAKE_BIT]    <= brk_r[axis_r];
          rdata_o[asr_pkg::STAT_PWRBRAKE_BIT] <= pwr_r[axis_r];
          rdata_o[asr_pkg::STAT_REF_BIT]      <= found_r[axis_r];
          rdata_o[asr_pkg::STAT_SEARCH_BIT]   <= srch_r[axis_r];
          rdata_o[asr_pkg::STAT_DIR_BIT]      <= dir_r[axis_r];
          rdata_o[asr_pkg::STAT_MOVING_BIT]   <= moving_i[axis_r];
        end
        asr_pkg::OFS_ENC_MODE: rdata_o[1:0] <= enc_r;
        asr_pkg::OFS_POS_READ: rdata_o <= pos_r[axis_r];
        default:               rdata_o <= asr_pkg::ZERO_WORD;
      endcase
    end else begin
      rdata_o <= asr_pkg::ZERO_WORD;
    end
  end

endmodule // asr_axis_ctrl

// ---- hw/asr_pkg.sv ----
// Purpose: Shared constants and types for the axis select / reference block
// Assumes: Four axes, 32-bit position counters
// Notes:   Register offsets are byte addresses on the plain register port
package asr_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int AXES    = 4;
  localparam int POS_W   = 32;
  localparam int AXIS_W  = 2;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_AXIS_SEL  = 8'h00;
  localparam logic [7:0] OFS_AXIS_CTRL = 8'h04;
  localparam logic [7:0] OFS_AXIS_STAT = 8'h08;
  localparam logic [7:0] OFS_ENC_MODE  = 8'h0C;
  localparam logic [7:0] OFS_POS_SET   = 8'h10;
  localparam logic [7:0] OFS_POS_READ  = 8'h14;
  localparam logic [7:0] OFS_SEARCH    = 8'h18;
  localparam logic [7:0] OFS_BRAKE     = 8'h1C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_ENABLE_BIT   = 0;  // Axis on / off
  localparam int CTRL_PWRBRAKE_BIT = 1;  // Power-up brake default
  localparam int CTRL_ORIGIN_BIT   = 3;  // Position set to origin
  localparam int ENC_PAIR0_BIT     = 0;  // Axes 1,2 differential
  localparam int ENC_PAIR1_BIT     = 1;  // Axes 3,4 differential
  localparam int STAT_ENABLE_BIT   = 0;
  localparam int STAT_BRAKE_BIT    = 1;
  localparam int STAT_PWRBRAKE_BIT = 2;
  localparam int STAT_REF_BIT      = 3;
  localparam int STAT_SEARCH_BIT   = 4;
  localparam int STAT_DIR_BIT      = 5;
  localparam int STAT_MOVING_BIT   = 6;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [AXIS_W-1:0] AXIS_RESET = 2'h0;
  localparam logic [POS_W-1:0]  POS_ORIGIN = 32'h0000_0000;
  localparam logic [31:0]       ZERO_WORD  = 32'h0000_0000;

  // Reference search options
  typedef enum logic [1:0] {
    SRCH_POS,
    SRCH_NEG,
    SRCH_LEVEL,
    SRCH_LEVEL_INV
  } asr_search_type;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } asr_req_type;

  // Per-axis motion drive toward the motion core
  typedef struct packed {
    logic             run;
    logic             dir_neg;
    logic [POS_W-1:0] target_shift;
    logic             shift_stb;
  } asr_move_type;

endpackage
